// *** verilog/sorf_top.sv ***
// safety output stage: four output blocks, terminals, test pulses, apb registers
//
// Summary of operation
// - outputs active while input true, else off
// - manual restart needed after each input fall
// - manual restart accepts only low-to-high transition
// - monitored restart needs low-high-low sequence
// - feedback must drop within window, else error
// - fault lamp flashes on error, else off
// - power-on check: feedback held high
// - feedback error latched until power cycle
// - error report true when feedback error detected
// - report cleared by power cycle or operator
// - status tap shows current output state
// - layouts: four single, two double, mixed
// - terminal used only when restart or monitoring
// - several blocks may share one restart terminal
// - logic input may be inverted
// - test pulses disabled: no dips, safety lost
// - configuration selects the restart terminal
// - unused terminals become ordinary inputs
`timescale 1ns/1ps
`include "sorf_regs.svh"
module sorf_top #(
    parameter int MS_CYCLES = `SORF_MS_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SORF_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // schematic side
    input wire logic [`SORF_NBLK-1:0] logic_in,
    input wire logic reset_operator,
    output logic [`SORF_NBLK-1:0] status_tap,
    output logic [`SORF_NBLK-1:0] error_out,
    output logic [`SORF_NBLK-1:0] spare_input,
    // terminals
    input wire logic [`SORF_NBLK-1:0] rf_pin,
    output logic [`SORF_NPAIR-1:0] channel_a_output,
    output logic [`SORF_NPAIR-1:0] channel_b_output,
    output logic [`SORF_NPAIR-1:0] fault_lamp
);
    localparam int NB = `SORF_NBLK;
    localparam int NP = `SORF_NPAIR;

    // configuration and apb state
    sorf_pkg::sorf_layout_e layout_r;
    logic [31:0] cfg_r [NB];
    logic [31:0] prdata_r;
    logic [31:0] rd_data;

    // synchroniser, timebase, test pulse
    logic [NB-1:0] rf_meta_r, rf_s_r;
    logic [16:0] ms_cnt_r;
    logic ms_tick_r;
    logic [15:0] flash_cnt_r, tp_cnt_r;
    logic blink_r;
    logic [7:0] dip_cnt_r;
    logic dip_r;
    logic por_done_r;

    // output registers
    logic [NB-1:0] ch_r, stat_r, err_out_r, spare_r;
    logic [NP-1:0] lamp_r;

    // per block signals
    wire [NB-1:0] manual, monitored, ktime, fbk_unc, invert, no_tp, err_en, stat_en;
    wire [NB-1:0] blk_active, b_uses, rf_blk;
    wire [NB-1:0] b_on, b_err, b_wait, b_rep, b_lamp;
    wire [NB-1:0] ch_nxt, ch_lamp;
    wire [NP-1:0] lamp_nxt;
    wire [NB-1:0] hit_cfg;
    logic [NB-1:0] used_term;
    logic [1:0] own [NB];

    // apb decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire hit_ctrl = (paddr == `SORF_ADDR_CTRL);
    wire hit_stat = (paddr == `SORF_ADDR_STAT);
    wire hit_any = hit_ctrl | hit_stat | (|hit_cfg);
    wire wr_en = access & pwrite;
    wire por_check = ms_tick_r & ~por_done_r;
    wire ms_wrap = (ms_cnt_r == 17'(MS_CYCLES - 1));
    wire flash_wrap = (flash_cnt_r == 16'(`SORF_FLASH_MS - 1));
    wire tp_wrap = (tp_cnt_r == 16'(`SORF_TP_PERIOD_MS - 1));
    wire [31:0] stat_word = {12'h000, b_rep, no_tp, b_wait, b_err, b_on};

    // layout decode
    wire lay_four = (layout_r == sorf_pkg::LAY_FOUR);
    wire lay_two = (layout_r == sorf_pkg::LAY_TWO_DOUBLE);
    wire lay_mix = (layout_r == sorf_pkg::LAY_MIXED);

    // a bad layout code disables every block rather than guessing a mapping
    assign blk_active = lay_four ? `SORF_MASK_FOUR :
                        lay_two ? `SORF_MASK_TWO :
                        lay_mix ? `SORF_MASK_MIXED : `SORF_MASK_NONE;

    // block owning each physical channel
    always_comb begin
        own[0] = 2'h0;
        own[1] = lay_two ? 2'h0 : 2'h1;
        own[2] = lay_two ? 2'h1 : 2'h2;
        own[3] = lay_four ? 2'h3 : (lay_two ? 2'h1 : 2'h2);
    end

    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_blk
            wire [`SORF_AW-1:0] cfg_addr = `SORF_ADDR_CFG0 + `SORF_ADDR_STEP * 12'(gi);
            wire [1:0] sel = cfg_r[gi][`SORF_CFG_SEL_HI:`SORF_CFG_SEL_LO];
            assign hit_cfg[gi] = (paddr == cfg_addr);
            assign manual[gi] = cfg_r[gi][`SORF_CFG_MANUAL];
            assign monitored[gi] = cfg_r[gi][`SORF_CFG_MONITOR];
            assign ktime[gi] = cfg_r[gi][`SORF_CFG_KTIME];
            assign fbk_unc[gi] = cfg_r[gi][`SORF_CFG_FBK_UNC];
            assign invert[gi] = cfg_r[gi][`SORF_CFG_INVERT];
            assign no_tp[gi] = cfg_r[gi][`SORF_CFG_NO_TP];
            assign err_en[gi] = cfg_r[gi][`SORF_CFG_ERR_EN];
            assign stat_en[gi] = cfg_r[gi][`SORF_CFG_STAT_EN];
            // several blocks may name the same terminal
            assign rf_blk[gi] = rf_s_r[sel];
            assign b_uses[gi] = blk_active[gi] & (manual[gi] | ktime[gi] | ~fbk_unc[gi]);

            sorf_block u_blk (
                .pclk(pclk),
                .presetn(presetn),
                .active(blk_active[gi]),
                .manual(manual[gi]),
                .monitored(monitored[gi]),
                .ktime(ktime[gi]),
                .fbk_unc(fbk_unc[gi]),
                .invert(invert[gi]),
                .window_ms(cfg_r[gi][`SORF_CFG_WIN_HI:`SORF_CFG_WIN_LO]),
                .logic_in(logic_in[gi]),
                .rf_level(rf_blk[gi]),
                .sys_clear(reset_operator),
                .ms_tick(ms_tick_r),
                .blink(blink_r),
                .por_check(por_check),
                .out_on(b_on[gi]),
                .err(b_err[gi]),
                .waiting(b_wait[gi]),
                .err_report(b_rep[gi]),
                .lamp(b_lamp[gi])
            );
        end
    endgenerate

    // terminals claimed by any block
    always_comb begin
        used_term = '0;
        for (int b = 0; b < NB; b++) begin
            if (b_uses[b]) begin
                used_term[cfg_r[b][`SORF_CFG_SEL_HI:`SORF_CFG_SEL_LO]] = 1'b1;
            end
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < NB; gc++) begin : g_ch
            // both channels of a double block dip together
            assign ch_nxt[gc] = b_on[own[gc]] & ~(dip_r & ~no_tp[own[gc]]);
            assign ch_lamp[gc] = b_lamp[own[gc]];
        end
        for (gc = 0; gc < NP; gc++) begin : g_pair
            assign lamp_nxt[gc] = ch_lamp[2 * gc] | ch_lamp[2 * gc + 1];
            assign channel_a_output[gc] = ch_r[2 * gc];
            assign channel_b_output[gc] = ch_r[2 * gc + 1];
            assign fault_lamp[gc] = lamp_r[gc];
        end
    endgenerate

    // register read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_data = 32'(layout_r);
        end
        if (hit_stat) begin
            rd_data = stat_word;
        end
        for (int i = 0; i < NB; i++) begin
            if (hit_cfg[i]) begin
                rd_data = cfg_r[i];
            end
        end
    end

    // apb registers; read data captured in setup so the access phase has no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            layout_r <= sorf_pkg::sorf_layout_e'(`SORF_CTRL_RST);
            prdata_r <= 32'h0000_0000;
        end else begin
            if (wr_en & hit_ctrl) begin
                layout_r <= sorf_pkg::sorf_layout_e'(pwdata[`SORF_LAYOUT_HI:`SORF_LAYOUT_LO]);
            end
            if (setup) begin
                prdata_r <= rd_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NB; i++) begin
                cfg_r[i] <= `SORF_CFG_RST;
            end
        end else begin
            for (int i = 0; i < NB; i++) begin
                if (wr_en & hit_cfg[i]) begin
                    cfg_r[i] <= pwdata;
                end
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = access & ~hit_any;

    // terminal synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // terminals idle at supply; a low reset value would fake a restart rise
            rf_meta_r <= '1;
            rf_s_r <= '1;
        end else begin
            rf_meta_r <= rf_pin;
            rf_s_r <= rf_meta_r;
        end
    end

    // millisecond tick for feedback windows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_r <= '0;
            ms_tick_r <= 1'b0;
        end else begin
            ms_cnt_r <= ms_wrap ? 17'h00000 : ms_cnt_r + 17'h00001;
            ms_tick_r <= ms_wrap;
        end
    end

    // power-on feedback check runs once, on the first tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_done_r <= 1'b0;
        end else if (ms_tick_r) begin
            por_done_r <= 1'b1;
        end
    end

    // lamp flash rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_r <= '0;
            blink_r <= 1'b0;
        end else if (ms_tick_r) begin
            flash_cnt_r <= flash_wrap ? 16'h0000 : flash_cnt_r + 16'h0001;
            blink_r <= blink_r ^ flash_wrap;
        end
    end

    // periodic voltage dip; short enough that loads do not drop out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tp_cnt_r <= '0;
            dip_cnt_r <= '0;
            dip_r <= 1'b0;
        end else begin
            if (ms_tick_r) begin
                tp_cnt_r <= tp_wrap ? 16'h0000 : tp_cnt_r + 16'h0001;
            end
            if (ms_tick_r & tp_wrap) begin
                dip_cnt_r <= 8'(`SORF_TP_DIP_CYC);
            end else if (dip_cnt_r != 8'h00) begin
                dip_cnt_r <= dip_cnt_r - 8'h01;
            end
            dip_r <= (dip_cnt_r != 8'h00);
        end
    end

    // output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_r <= '0;
            stat_r <= '0;
            err_out_r <= '0;
            spare_r <= '0;
            lamp_r <= '0;
        end else begin
            ch_r <= ch_nxt;
            stat_r <= b_on & stat_en;
            err_out_r <= b_rep & err_en;
            spare_r <= rf_s_r & ~used_term;
            lamp_r <= lamp_nxt;
        end
    end

    assign status_tap = stat_r;
    assign error_out = err_out_r;
    assign spare_input = spare_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    dbl_match_a: assert property (lay_two |=> (ch_r[0] == ch_r[1]) && (ch_r[2] == ch_r[3]))
        else $error("double block channels differ");
    dip_drop_a: assert property ((dip_r && b_on[0] && !no_tp[0]) |=> !ch_r[0])
        else $error("test dip missing on channel");
    no_dip_a: assert property ((b_on[0] && no_tp[0]) |=> ch_r[0])
        else $error("dip applied with test pulses disabled");
    spare_mask_a: assert property (1'b1 |=> ((spare_input & $past(used_term)) == '0))
        else $error("claimed terminal shown as spare input");
    status_tap_a: assert property ((stat_en[0] && b_on[0]) |=> status_tap[0])
        else $error("status tap does not show output");
    err_gate_a: assert property ((b_rep[1] && err_en[1]) |=> error_out[1])
        else $error("error output not raised");
    por_once_a: assert property (por_done_r |-> !por_check)
        else $error("power-on check repeated");
    apb_err_a: assert property ((access && !hit_any) |-> pslverr && pready)
        else $error("unmapped access not refused");
endmodule // sorf_top

// *** common/sorf_regs.svh ***
// register map, field positions and timing constants of the safety output block
`ifndef SORF_REGS_SVH
`define SORF_REGS_SVH
`define SORF_AW 12
`define SORF_NBLK 4
`define SORF_NPAIR 2
`define SORF_ADDR_CTRL 12'h000
`define SORF_ADDR_CFG0 12'h004
`define SORF_ADDR_STEP 12'h004
`define SORF_ADDR_STAT 12'h014
`define SORF_CTRL_RST 2'h0
`define SORF_CFG_RST 32'h0000_0000
`define SORF_LAYOUT_HI 1
`define SORF_LAYOUT_LO 0
`define SORF_CFG_MANUAL 0
`define SORF_CFG_MONITOR 1
`define SORF_CFG_KTIME 2
`define SORF_CFG_FBK_UNC 3
`define SORF_CFG_INVERT 4
`define SORF_CFG_NO_TP 5
`define SORF_CFG_ERR_EN 6
`define SORF_CFG_STAT_EN 7
`define SORF_CFG_SEL_HI 9
`define SORF_CFG_SEL_LO 8
`define SORF_CFG_WIN_HI 31
`define SORF_CFG_WIN_LO 16
`define SORF_MASK_FOUR 4'hF
`define SORF_MASK_TWO 4'h3
`define SORF_MASK_MIXED 4'h7
`define SORF_MASK_NONE 4'h0
`define SORF_CLK_HZ 100000000
`define SORF_TICK_MS 1
`define SORF_MS_CYCLES (`SORF_CLK_HZ / 1000 * `SORF_TICK_MS)
`define SORF_FBK_RETURN_S 10
`define SORF_FBK_RETURN_MS (`SORF_FBK_RETURN_S * 1000)
`define SORF_FLASH_MS 250
`define SORF_TP_PERIOD_MS 40
`define SORF_TP_DIP_NS 400
`define SORF_TP_DIP_CYC (`SORF_TP_DIP_NS * (`SORF_CLK_HZ / 1000000) / 1000)
`endif

// *** common/sorf_pkg.sv ***
// types shared by the safety output block files
package sorf_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_WAIT_RISE = 2'b01,
        ST_WAIT_FALL = 2'b10,
        ST_ON = 2'b11
    } sorf_state_e;
    typedef enum logic [1:0] {
        LAY_FOUR = 2'b00,
        LAY_TWO_DOUBLE = 2'b01,
        LAY_MIXED = 2'b10,
        LAY_BAD = 2'b11
    } sorf_layout_e;
    typedef logic [15:0] sorf_ms_t;
endpackage

// *** verilog/sorf_block.sv ***
// one output block: restart modes, feedback timing, error latch and report
`timescale 1ns/1ps
`include "sorf_regs.svh"
module sorf_block (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input wire logic active,
    input wire logic manual,
    input wire logic monitored,
    input wire logic ktime,
    input wire logic fbk_unc,
    input wire logic invert,
    input wire sorf_pkg::sorf_ms_t window_ms,
    // schematic input, terminal level, reset operator
    input wire logic logic_in,
    input wire logic rf_level,
    input wire logic sys_clear,
    // timebase
    input wire logic ms_tick,
    input wire logic blink,
    input wire logic por_check,
    // results
    output logic out_on,
    output logic err,
    output logic waiting,
    output logic err_report,
    output logic lamp
);
    sorf_pkg::sorf_state_e state_r, state_nxt;
    sorf_pkg::sorf_ms_t tmr_cnt_r;
    logic rf_prev_r, on_prev_r, err_r, report_r, tmr_run_r;

    wire go = active & (logic_in ^ invert) & ~err_r;
    wire rf_rise = rf_level & ~rf_prev_r;
    wire rf_fall = ~rf_level & rf_prev_r;
    wire use_fbk = active & ~fbk_unc;
    wire on_now = (state_r == sorf_pkg::ST_ON);
    // window opens at switch-on with time monitoring, at switch-off without
    wire tmr_start = ktime ? (on_now & ~on_prev_r) : (~on_now & on_prev_r);
    wire tmr_done = ktime ? (~rf_level | ~on_now) : (rf_level | on_now);
    wire [15:0] tmr_limit = ktime ? window_ms : 16'(`SORF_FBK_RETURN_MS);
    wire tmr_fail = tmr_run_r & ~tmr_done & ms_tick & (tmr_cnt_r >= tmr_limit);
    wire por_fail = por_check & ~ktime & ~rf_level;
    wire fail = use_fbk & (tmr_fail | por_fail);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sorf_pkg::ST_OFF: begin
                if (go) begin
                    state_nxt = manual ? sorf_pkg::ST_WAIT_RISE : sorf_pkg::ST_ON;
                end
            end
            sorf_pkg::ST_WAIT_RISE: begin
                if (!go) begin
                    state_nxt = sorf_pkg::ST_OFF;
                end else if (rf_rise) begin
                    state_nxt = monitored ? sorf_pkg::ST_WAIT_FALL : sorf_pkg::ST_ON;
                end
            end
            sorf_pkg::ST_WAIT_FALL: begin
                if (!go) begin
                    state_nxt = sorf_pkg::ST_OFF;
                end else if (rf_fall) begin
                    state_nxt = sorf_pkg::ST_ON;
                end
            end
            sorf_pkg::ST_ON: begin
                if (!go) begin
                    state_nxt = sorf_pkg::ST_OFF;
                end
            end
        endcase
    end

    // previous sample resets high so a held button is no restart after power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= sorf_pkg::ST_OFF;
            rf_prev_r <= 1'b1;
            on_prev_r <= 1'b0;
            err_r <= 1'b0;
            report_r <= 1'b0;
            tmr_run_r <= 1'b0;
            tmr_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            rf_prev_r <= rf_level;
            on_prev_r <= on_now;
            err_r <= err_r | fail;
            report_r <= fail | (report_r & ~sys_clear);
            if (tmr_start) begin
                tmr_run_r <= 1'b1;
                tmr_cnt_r <= '0;
            end else if (tmr_done | tmr_fail) begin
                tmr_run_r <= 1'b0;
            end else if (ms_tick) begin
                tmr_cnt_r <= tmr_cnt_r + 16'h0001;
            end
        end
    end

    assign out_on = on_now;
    assign err = err_r;
    assign waiting = (state_r == sorf_pkg::ST_WAIT_RISE) | (state_r == sorf_pkg::ST_WAIT_FALL);
    assign err_report = report_r;
    assign lamp = err_r & blink;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_armed_rise;
        (state_r == sorf_pkg::ST_WAIT_RISE) && go && rf_rise && monitored;
    endsequence
    sequence s_release;
        go && rf_fall;
    endsequence

    off_when_low_a: assert property (!go |=> !out_on)
        else $error("output on while input false");
    auto_follow_a: assert property ((go && !manual && state_r == sorf_pkg::ST_OFF) |=> out_on)
        else $error("automatic output did not follow input");
    rise_needed_a: assert property ((state_r == sorf_pkg::ST_WAIT_RISE && !rf_rise) |=> !out_on)
        else $error("output on without restart rise");
    monitored_seq_a: assert property (s_armed_rise ##1 s_release |=> out_on)
        else $error("monitored restart did not enable output");
    fail_shuts_a: assert property (fail |=> err_r ##1 !out_on)
        else $error("feedback failure did not switch output off");
    err_sticky_a: assert property (err_r |=> err_r)
        else $error("feedback error cleared without power cycle");
    lamp_quiet_a: assert property (!err_r |-> !lamp)
        else $error("fault lamp lit without error");
    report_set_a: assert property (fail |=> err_report)
        else $error("error report not raised");
endmodule // sorf_block

// *** verif/sorf_contactor_model.sv ***
// external contactors with closed-when-idle contacts and restart buttons
`timescale 1ns/1ps
module sorf_contactor_model #(
    parameter int DELAY = 200
) (
    // clock
    input wire logic pclk,
    // coils, one per physical channel
    input wire logic [3:0] coil,
    // terminal use and faults commanded by the bench
    input wire logic [3:0] btn_mode,
    input wire logic [3:0] press,
    input wire logic [3:0] open_fault,
    // terminal levels
    output logic [3:0] rf
);
    int cnt [4];
    logic [3:0] closed = 4'h0;
    // slow armature: contact follows the coil only after DELAY cycles
    always @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            if (coil[i] !== closed[i]) begin
                cnt[i]++;
                if (cnt[i] >= DELAY) begin
                    closed[i] <= coil[i];
                    cnt[i] = 0;
                end
            end else begin
                cnt[i] = 0;
            end
        end
    end
    // idle contacts tie the terminal to supply
    // an open wire leaves the terminal without supply
    assign rf = (btn_mode & press) | (~btn_mode & ~closed & ~open_fault);
endmodule // sorf_contactor_model

// *** verif/sorf_top_tb.sv ***
// self-checking bench for the safety output stage
`timescale 1ns/1ps
`include "sorf_regs.svh"
module sorf_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] logic_in = 4'h0, status_tap, error_out, spare_input, rf_pin, coil;
    logic [3:0] bmode = 4'h0, press = 4'h0, ofault = 4'h0;
    logic reset_operator = 0, err, l0;
    logic [1:0] cha, chb, lamp;
    int n_mismatch = 0, comparisons = 0;
    assign coil = {chb[1], cha[1], chb[0], cha[0]};
    sorf_top #(.MS_CYCLES(10)) u_sorf_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .logic_in(logic_in),
        .reset_operator(reset_operator), .status_tap(status_tap), .error_out(error_out),
        .spare_input(spare_input), .rf_pin(rf_pin), .channel_a_output(cha),
        .channel_b_output(chb), .fault_lamp(lamp));
    sorf_contactor_model u_sorf_contactor_model (.pclk(pclk), .coil(coil), .btn_mode(bmode),
        .press(press), .open_fault(ofault), .rf(rf_pin));
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        // only the watchdog ends a wait for a slave that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic dut_reset();
        @(posedge pclk);
        presetn <= 0;
        logic_in <= 4'h0;
        bmode <= 4'h0;
        press <= 4'h0;
        cyc(5);
        presetn <= 1;
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(20000 * 10);
        n_mismatch++;
        final_report();
    end
    initial begin
        dut_reset();
        apb(0, `SORF_ADDR_CFG0, 0);
        chk("cfg0 reset", rd, `SORF_CFG_RST);
        apb(0, `SORF_ADDR_STAT, 0);
        chk("status reset", rd, 32'h0);
        apb(0, 12'h100, 0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1, 12'h008, 32'h0000_0038); // invert, unconnected, no test pulse
        apb(1, `SORF_ADDR_CFG0, 32'h0000_00A8);
        apb(0, 12'h008, 0);
        chk("cfg1 readback", rd, 32'h0000_0038);
        logic_in <= 4'h1;
        cyc(4);
        chk("auto on", {30'h0, chb[0], cha[0]}, 32'h3);
        chk("status tap", {28'h0, status_tap[1:0]}, 32'h1);
        apb(0, `SORF_ADDR_STAT, 0);
        chk("safety lost", {28'h0, rd[15:12]}, 32'h3);
        logic_in <= 4'h2;
        cyc(4);
        chk("auto off", {30'h0, chb[0], cha[0]}, 32'h0);
        apb(1, 12'h00C, 32'h0000_0229);
        apb(1, 12'h010, 32'h0000_032B);
        bmode <= 4'hC;
        logic_in <= 4'hC;
        cyc(10);
        chk("manual held", {31'h0, cha[1]}, 32'h0);
        apb(0, `SORF_ADDR_STAT, 0);
        chk("waiting", {28'h0, rd[11:8]}, 32'hC);
        press <= 4'h4;
        cyc(6);
        chk("manual go", {31'h0, cha[1]}, 32'h1);
        logic_in <= 4'h8;
        cyc(2);
        logic_in <= 4'hC;
        cyc(8);
        chk("held button", {31'h0, cha[1]}, 32'h0);
        press <= 4'h8;
        cyc(6);
        chk("monitored rise", {31'h0, chb[1]}, 32'h0);
        press <= 4'h0;
        cyc(6);
        chk("monitored fall", {31'h0, chb[1]}, 32'h1);
        dut_reset();
        apb(1, `SORF_ADDR_CFG0, 32'h0002_0064);
        logic_in <= 4'h1;
        cyc(5);
        chk("fbk window on", {31'h0, cha[0]}, 32'h1);
        cyc(40);
        chk("fbk late off", {31'h0, cha[0]}, 32'h0);
        chk("error out", {28'h0, error_out}, 32'h1);
        apb(0, `SORF_ADDR_STAT, 0);
        chk("err latched", {15'h0, rd[16], 12'h0, rd[7:4]}, 32'h10001);
        l0 = lamp[0];
        cyc(2600);
        chk("lamp flash", {30'h0, lamp}, {31'h0, ~l0});
        reset_operator <= 1;
        cyc(1);
        reset_operator <= 0;
        cyc(3);
        chk("report clear", {28'h0, error_out}, 32'h0);
        chk("latch holds", {31'h0, cha[0]}, 32'h0);
        ofault <= 4'h1;
        dut_reset();
        cyc(30);
        apb(0, `SORF_ADDR_STAT, 0);
        // all four default blocks watch terminal 0, so all of them fail
        chk("power-on check", rd, 32'h000F_00F0);
        ofault <= 4'h0;
        dut_reset();
        apb(1, `SORF_ADDR_CTRL, 32'h1);
        apb(1, `SORF_ADDR_CFG0, 32'h0000_00A8);
        logic_in <= 4'h1;
        cyc(4);
        chk("double pair", {28'h0, coil}, 32'h3);
        apb(1, `SORF_ADDR_CTRL, 32'h3);
        cyc(4);
        chk("all off", {28'h0, coil}, 32'h0);
        chk("spare inputs", {28'h0, spare_input}, 32'hF);
        apb(1, `SORF_ADDR_CTRL, 32'h2);
        logic_in <= 4'h5;
        cyc(4);
        chk("mixed layout", {28'h0, coil}, 32'hD);
        final_report();
    end
endmodule // sorf_top_tb
